// [design/tsa_sensor_end.sv]
// Sensor end: scratchpad, alarm, identity code and power-mode logic
// Operation
// - Result is sign-extended 16-bit two's complement
// - Low result bits undefined below 12 bits
// - External supply: busy slots read 0, then 1
// - Result reads +85 before first conversion
// - Trip bytes are signed 8-bit values
// - Compare only result bits 11 to 4
// - Alarm when at/below lower or at/above upper
// - Alarm flag re-evaluated after every conversion
// - Flagged scan answered only with alarm set
// - Master reconverts after changing trips in alarm
// - Parasite mode: master holds strong pullup
// - No bus traffic during strong pullup
// - Supply query slot: parasite pulls low
// - Identity: family, 48-bit serial, top CRC
// - Bytes 0,1 return result, never written
// - Bytes 2,3 are upper and lower trips
// - Byte 4 config; bytes 5-7 ignore writes
// - Byte 8 is CRC of bytes 0-7
// - Load writes three bytes from byte 2
// - Readout sends from byte 0, LSB first
// - Commit copies trips and config to storage
// - Power-up reloads stored trips and config
// - Reload command; slots read 0 then 1 (code answers only on external supply)
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "tsa_defs.svh"
module tsa_sensor_end #(
    parameter int MEASURE_CYC = `TSA_MEASURE_MS * `TSA_CLK_KHZ,
    parameter int COMMIT_CYC = `TSA_COMMIT_MS * `TSA_CLK_KHZ,
    parameter int RELOAD_CYC = `TSA_RELOAD_US * `TSA_CLK_KHZ / 1000,
    // Arbitrary identity values
    parameter logic [7:0] FAMILY = 8'h5a,
    parameter logic [47:0] SERIAL = 48'h0123_4567_89ab
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    tsa_link_if.sensor link,
    input wire logic parasite_pin,
    input wire logic [15:0] sense_temp,
    output logic [15:0] temp_result,
    output logic alarm_flag,
    output logic job_busy
);

////////////////////////////////////////////////////////////////////////////////
// Elaboration checks and helpers

if (MEASURE_CYC < 8 || COMMIT_CYC < 1 || RELOAD_CYC < 1) begin : g_bad_timing
    $error("Timing counts too small");
end

function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
    logic [7:0] c;
    logic fb;
    c = 8'h00;
    for (int i = 0; i < 64; i++) begin
        if (i < n) begin
            fb = c[0] ^ d[i];
            c = c >> 1;
            if (fb) begin
                c = c ^ `TSA_CRC_POLY;
            end
        end
    end
    return c;
endfunction

////////////////////////////////////////////////////////////////////////////////
// State

tsa_pkg::tsa_dev_state_type state_q;
tsa_pkg::tsa_job_type job_q;
logic [31:0] job_cnt_q;
logic [6:0] cnt_q;
logic [15:0] temp_q;
logic [7:0] upper_q, lower_q, cfg_q;
logic [7:0] nv_upper_q, nv_lower_q, nv_cfg_q;
logic alarm_q;
logic bit_stb_q, bit_val_q;
logic par_meta_q, par_q;
logic [63:0] sp_bytes;
logic [71:0] sp_all;
logic [63:0] ident;
logic [1:0] res;
logic [31:0] conv_len;
logic func_byte, wr_en, job_done;
logic start_conv, start_commit, start_reload;
logic signed [7:0] t_cmp;

assign res = cfg_q[`TSA_CFG_RES_LSB +: 2];
assign conv_len = MEASURE_CYC >> (2'd3 - res);
assign sp_bytes = {`TSA_RSV_C_RST, `TSA_RSV_B_RST, `TSA_RSV_A_RST,
                   cfg_q, lower_q, upper_q, temp_q};
assign sp_all = {crc8(sp_bytes, 64), sp_bytes};
assign ident = {crc8({8'h00, SERIAL, FAMILY}, 56), SERIAL, FAMILY};
assign func_byte = (state_q == tsa_pkg::S_FUNC) && link.byte_stb;
assign wr_en = (state_q == tsa_pkg::S_WRSP) && link.byte_stb;
// A new job is refused while another one runs
assign start_conv = func_byte && link.byte_val == `TSA_CMD_MEASURE && job_q == tsa_pkg::J_NONE;
assign start_commit = func_byte && link.byte_val == `TSA_CMD_COMMIT && job_q == tsa_pkg::J_NONE;
assign start_reload = func_byte && link.byte_val == `TSA_CMD_RELOAD && job_q == tsa_pkg::J_NONE;
assign job_done = (job_q != tsa_pkg::J_NONE) && job_cnt_q == 32'd1;
assign t_cmp = temp_q[11:4];

assign temp_result = temp_q;
assign alarm_flag = alarm_q;
assign job_busy = (job_q != tsa_pkg::J_NONE);
assign link.bit_stb = bit_stb_q;
assign link.bit_val = bit_val_q;

////////////////////////////////////////////////////////////////////////////////
// Supply-mode strap synchroniser

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        par_meta_q <= 1'b0;
        par_q <= 1'b0;
    end else begin
        par_meta_q <= parasite_pin;
        par_q <= par_meta_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Background jobs; reset starts a reload so stored values reach the scratchpad

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        job_q <= tsa_pkg::J_RELOAD;
        job_cnt_q <= 32'd1;
    end else if (job_q == tsa_pkg::J_NONE) begin
        if (start_conv) begin
            job_q <= tsa_pkg::J_CONV;
            job_cnt_q <= conv_len;
        end else if (start_commit) begin
            job_q <= tsa_pkg::J_COMMIT;
            job_cnt_q <= COMMIT_CYC;
        end else if (start_reload) begin
            job_q <= tsa_pkg::J_RELOAD;
            job_cnt_q <= RELOAD_CYC;
        end
    end else if (job_done) begin
        job_q <= tsa_pkg::J_NONE;
        job_cnt_q <= 32'd0;
    end else begin
        job_cnt_q <= job_cnt_q - 32'd1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Result and alarm

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        temp_q <= `TSA_TEMP_RST;
    end else if (job_done && job_q == tsa_pkg::J_CONV) begin
        // Undefined low bits read as zero
        temp_q <= sense_temp & (16'hffff << (2'd3 - res));
    end
end

// Judged one cycle after the result lands, on the stored value
logic judge_q;
always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        judge_q <= 1'b0;
        alarm_q <= 1'b0;
    end else begin
        judge_q <= job_done && job_q == tsa_pkg::J_CONV;
        if (judge_q) begin
            alarm_q <= (t_cmp <= $signed(lower_q)) || (t_cmp >= $signed(upper_q));
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Scratchpad trips and config, nonvolatile copy

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        upper_q <= `TSA_UPPER_RST;
        lower_q <= `TSA_LOWER_RST;
        cfg_q <= `TSA_CFG_RST;
    end else if (job_done && job_q == tsa_pkg::J_RELOAD) begin
        upper_q <= nv_upper_q;
        lower_q <= nv_lower_q;
        cfg_q <= nv_cfg_q;
    end else if (wr_en) begin
        // Only bytes 2..4 are writable; others drop the byte
        if (cnt_q == 7'd0) begin
            upper_q <= link.byte_val;
        end else if (cnt_q == 7'd1) begin
            lower_q <= link.byte_val;
        end else if (cnt_q == 7'd2) begin
            cfg_q <= (link.byte_val & `TSA_CFG_RES_MASK) | `TSA_CFG_FIXED;
        end
    end
end

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        nv_upper_q <= `TSA_UPPER_RST;
        nv_lower_q <= `TSA_LOWER_RST;
        nv_cfg_q <= `TSA_CFG_RST;
    end else if (job_done && job_q == tsa_pkg::J_COMMIT) begin
        nv_upper_q <= upper_q;
        nv_lower_q <= lower_q;
        nv_cfg_q <= cfg_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Link sequencer and read-slot answers

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_q <= tsa_pkg::S_IDLE;
        cnt_q <= 7'd0;
        bit_stb_q <= 1'b0;
        bit_val_q <= 1'b1;
    end else begin
        bit_stb_q <= link.slot_stb;
        bit_val_q <= 1'b1;
        if (link.init_pulse) begin
            state_q <= tsa_pkg::S_ROM;
            cnt_q <= 7'd0;
        end else begin
            case (state_q)
                tsa_pkg::S_ROM: begin
                    if (link.byte_stb) begin
                        cnt_q <= 7'd0;
                        if (link.byte_val == `TSA_CMD_SKIP) begin
                            state_q <= tsa_pkg::S_FUNC;
                        end else if (link.byte_val == `TSA_CMD_READ_ID ||
                                     link.byte_val == `TSA_CMD_SCAN) begin
                            state_q <= tsa_pkg::S_IDTX;
                        end else if (link.byte_val == `TSA_CMD_FLAG_SCAN && alarm_q) begin
                            state_q <= tsa_pkg::S_IDTX;
                        end else begin
                            state_q <= tsa_pkg::S_IDLE;
                        end
                    end
                end
                tsa_pkg::S_IDTX: begin
                    if (link.slot_stb) begin
                        bit_val_q <= ident[cnt_q[5:0]];
                        cnt_q <= cnt_q + 7'd1;
                        if (cnt_q == 7'd63) begin
                            state_q <= tsa_pkg::S_IDLE;
                        end
                    end
                end
                tsa_pkg::S_FUNC: begin
                    if (link.byte_stb) begin
                        cnt_q <= 7'd0;
                        case (link.byte_val)
                            `TSA_CMD_LOAD: state_q <= tsa_pkg::S_WRSP;
                            `TSA_CMD_READOUT: state_q <= tsa_pkg::S_RDSP;
                            `TSA_CMD_MEASURE: state_q <= tsa_pkg::S_STAT;
                            `TSA_CMD_COMMIT: state_q <= tsa_pkg::S_STAT;
                            `TSA_CMD_RELOAD: state_q <= tsa_pkg::S_STAT;
                            `TSA_CMD_SUPPLY: state_q <= tsa_pkg::S_PWR;
                            default: state_q <= tsa_pkg::S_IDLE;
                        endcase
                    end
                end
                tsa_pkg::S_WRSP: begin
                    if (link.byte_stb) begin
                        cnt_q <= cnt_q + 7'd1;
                        if (cnt_q == 7'd2) begin
                            state_q <= tsa_pkg::S_IDLE;
                        end
                    end
                end
                tsa_pkg::S_RDSP: begin
                    if (link.slot_stb) begin
                        bit_val_q <= sp_all[cnt_q];
                        cnt_q <= cnt_q + 7'd1;
                        if (cnt_q == 7'd71) begin
                            state_q <= tsa_pkg::S_IDLE;
                        end
                    end
                end
                tsa_pkg::S_STAT: begin
                    // Parasite power leaves the line to the pullup
                    if (link.slot_stb && !par_q) begin
                        bit_val_q <= (job_q == tsa_pkg::J_NONE);
                    end
                end
                tsa_pkg::S_PWR: begin
                    if (link.slot_stb) begin
                        bit_val_q <= !par_q;
                    end
                end
                default: begin
                    state_q <= tsa_pkg::S_IDLE;
                end
            endcase
        end
    end
end

endmodule

// [include/tsa_defs.svh]
// Offsets, reset values, commands and timing for the thermometer link
`ifndef TSA_DEFS_SVH
`define TSA_DEFS_SVH
// Timing: clock rate and documented periods in their own units
`define TSA_CLK_KHZ 20000
`define TSA_MEASURE_MS 750
`define TSA_COMMIT_MS 10
`define TSA_RELOAD_US 50
// Scratchpad byte offsets
`define TSA_SP_TEMP_LO 4'h0
`define TSA_SP_TEMP_HI 4'h1
`define TSA_SP_UPPER 4'h2
`define TSA_SP_LOWER 4'h3
`define TSA_SP_CONFIG 4'h4
`define TSA_SP_RSV_A 4'h5
`define TSA_SP_RSV_B 4'h6
`define TSA_SP_RSV_C 4'h7
`define TSA_SP_CHECK 4'h8
// Reset values
`define TSA_TEMP_RST 16'h0550
`define TSA_UPPER_RST 8'h4b
`define TSA_LOWER_RST 8'h46
`define TSA_CFG_RST 8'h7f
`define TSA_RSV_A_RST 8'hff
`define TSA_RSV_B_RST 8'h0c
`define TSA_RSV_C_RST 8'h10
// Config byte fields
`define TSA_CFG_RES_LSB 5
`define TSA_CFG_RES_MASK 8'h60
`define TSA_CFG_FIXED 8'h1f
// Checksum polynomial, reflected form
`define TSA_CRC_POLY 8'h8c
// Selection and function commands
`define TSA_CMD_READ_ID 8'h33
`define TSA_CMD_SCAN 8'hf0
`define TSA_CMD_FLAG_SCAN 8'hec
`define TSA_CMD_SKIP 8'hcc
`define TSA_CMD_LOAD 8'h4e
`define TSA_CMD_READOUT 8'hbe
`define TSA_CMD_MEASURE 8'h44
`define TSA_CMD_COMMIT 8'h48
`define TSA_CMD_RELOAD 8'hb8
`define TSA_CMD_SUPPLY 8'hb4
// Controller register offsets
`define TSA_HR_OP 4'h0
`define TSA_HR_DATA 4'h1
`define TSA_HR_STATUS 4'h2
`define TSA_HR_RX 4'h3
`define TSA_HR_PULLCFG 4'h4
// Controller operation codes and status bits
`define TSA_OP_RESET 2'h1
`define TSA_OP_BYTE 2'h2
`define TSA_OP_SLOT 2'h3
`define TSA_ST_BUSY 0
`define TSA_ST_BIT 1
`define TSA_ST_PULL 2
`define TSA_ST_PARASITE 3
`define TSA_ST_STALE 4
`endif

// [include/tsa_pkg.sv]
// Types shared by both ends of the thermometer link
package tsa_pkg;
    typedef enum logic [2:0] {
        S_IDLE, S_ROM, S_IDTX, S_FUNC, S_WRSP, S_RDSP, S_STAT, S_PWR
    } tsa_dev_state_type;
    typedef enum logic [1:0] {J_NONE, J_CONV, J_COMMIT, J_RELOAD} tsa_job_type;
    typedef enum logic [1:0] {H_IDLE, H_SLOT, H_PULL} tsa_host_state_type;
endpackage

// [include/tsa_link_if.sv]
// Byte and slot level link between controller and sensor
`timescale 1ns/10ps
interface tsa_link_if;
    logic init_pulse;
    logic byte_stb;
    logic [7:0] byte_val;
    logic slot_stb;
    logic strong_pullup;
    logic bit_stb;
    logic bit_val;
    modport master (
        output init_pulse, byte_stb, byte_val, slot_stb, strong_pullup,
        input bit_stb, bit_val
    );
    modport sensor (
        input init_pulse, byte_stb, byte_val, slot_stb, strong_pullup,
        output bit_stb, bit_val
    );
endinterface

// [design/tsa_master_end.sv]
// Controller end: register-driven sequencer for the thermometer link
`timescale 1ns/10ps
`include "tsa_defs.svh"
module tsa_master_end #(
    parameter int MEASURE_CYC = `TSA_MEASURE_MS * `TSA_CLK_KHZ,
    parameter int COMMIT_CYC = `TSA_COMMIT_MS * `TSA_CLK_KHZ
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    tsa_link_if.master link,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);

if (MEASURE_CYC < 1 || COMMIT_CYC < 1) begin : g_bad_timing
    $error("Pullup counts too small");
end

////////////////////////////////////////////////////////////////////////////////
// State

tsa_pkg::tsa_host_state_type state_q;
logic [7:0] data_q, rx_q, b0_q, b1_q, rdata_q;
logic [1:0] nbytes_q;
logic pull_en_q, last_bit_q, parasite_q, stale_q;
logic init_q, byte_q, slot_q;
logic [31:0] pull_cnt_q;
logic [1:0] op;
logic go;
logic is_func;

assign op = reg_wdata[1:0];
// Commands are refused while busy, including the strong pullup hold
assign go = reg_wr && reg_addr == `TSA_HR_OP && state_q == tsa_pkg::H_IDLE && !init_q &&
            !byte_q && !slot_q;
assign is_func = byte_q && nbytes_q == 2'd1;
assign link.init_pulse = init_q;
assign link.byte_stb = byte_q;
assign link.byte_val = data_q;
assign link.slot_stb = slot_q;
assign link.strong_pullup = (state_q == tsa_pkg::H_PULL);
assign reg_rdata = rdata_q;

////////////////////////////////////////////////////////////////////////////////
// Register file

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        data_q <= 8'h00;
        pull_en_q <= 1'b0;
        rdata_q <= 8'h00;
    end else begin
        if (reg_wr && reg_addr == `TSA_HR_DATA) begin
            data_q <= reg_wdata;
        end else if (reg_wr && reg_addr == `TSA_HR_PULLCFG) begin
            pull_en_q <= reg_wdata[0];
        end
        rdata_q <= 8'h00;
        if (reg_rd) begin
            if (reg_addr == `TSA_HR_DATA) begin
                rdata_q <= data_q;
            end else if (reg_addr == `TSA_HR_STATUS) begin
                rdata_q <= {3'h0, stale_q, parasite_q, link.strong_pullup, last_bit_q,
                            state_q != tsa_pkg::H_IDLE || init_q || byte_q || slot_q};
            end else if (reg_addr == `TSA_HR_RX) begin
                rdata_q <= rx_q;
            end else if (reg_addr == `TSA_HR_PULLCFG) begin
                rdata_q <= {7'h00, pull_en_q};
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Link sequencer

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_q <= tsa_pkg::H_IDLE;
        init_q <= 1'b0;
        byte_q <= 1'b0;
        slot_q <= 1'b0;
        pull_cnt_q <= 32'd0;
    end else begin
        init_q <= go && op == `TSA_OP_RESET;
        byte_q <= go && op == `TSA_OP_BYTE;
        slot_q <= go && op == `TSA_OP_SLOT;
        case (state_q)
            tsa_pkg::H_IDLE: begin
                if (slot_q) begin
                    state_q <= tsa_pkg::H_SLOT;
                end else if (is_func && pull_en_q && data_q == `TSA_CMD_MEASURE) begin
                    state_q <= tsa_pkg::H_PULL;
                    pull_cnt_q <= MEASURE_CYC;
                end else if (is_func && pull_en_q && data_q == `TSA_CMD_COMMIT) begin
                    state_q <= tsa_pkg::H_PULL;
                    pull_cnt_q <= COMMIT_CYC;
                end
            end
            tsa_pkg::H_SLOT: begin
                if (link.bit_stb) begin
                    state_q <= tsa_pkg::H_IDLE;
                end
            end
            tsa_pkg::H_PULL: begin
                pull_cnt_q <= pull_cnt_q - 32'd1;
                if (pull_cnt_q == 32'd1) begin
                    state_q <= tsa_pkg::H_IDLE;
                end
            end
            default: begin
                state_q <= tsa_pkg::H_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Received bits and command tracking

always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        rx_q <= 8'h00;
        last_bit_q <= 1'b1;
        parasite_q <= 1'b0;
        stale_q <= 1'b0;
        b0_q <= 8'h00;
        b1_q <= 8'h00;
        nbytes_q <= 2'd0;
    end else begin
        if (init_q) begin
            nbytes_q <= 2'd0;
        end else if (byte_q) begin
            if (nbytes_q == 2'd0) begin
                b0_q <= data_q;
            end else if (nbytes_q == 2'd1) begin
                b1_q <= data_q;
            end
            if (nbytes_q != 2'd3) begin
                nbytes_q <= nbytes_q + 2'd1;
            end
        end
        if (state_q == tsa_pkg::H_SLOT && link.bit_stb) begin
            // Bits arrive LSB first, shifted in from the top
            rx_q <= {link.bit_val, rx_q[7:1]};
            last_bit_q <= link.bit_val;
            if (b0_q == `TSA_CMD_SKIP && b1_q == `TSA_CMD_SUPPLY && nbytes_q == 2'd2) begin
                parasite_q <= !link.bit_val;
            end
        end
        // Trips changed: alarm untrusted until the next measurement
        if (is_func && data_q == `TSA_CMD_LOAD) begin
            stale_q <= 1'b1;
        end else if (is_func && data_q == `TSA_CMD_MEASURE) begin
            stale_q <= 1'b0;
        end
    end
end

endmodule

// [tb/tsa_link_sva.sv]
// Link checker between controller and sensor
`timescale 1ns/10ps
module tsa_link_sva #(
    parameter int MEASURE_CYC = 64,
    parameter int COMMIT_CYC = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic init_pulse,
    input wire logic byte_stb,
    input wire logic [7:0] byte_val,
    input wire logic slot_stb,
    input wire logic strong_pullup,
    input wire logic bit_stb,
    input wire logic bit_val
);
    logic [31:0] pull_cnt_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Wide counter: full conversion counts run to millions
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) pull_cnt_q <= 32'h0;
        else if (strong_pullup) pull_cnt_q <= pull_cnt_q + 32'h1;
        else pull_cnt_q <= 32'h0;
    end
    ////////////////////////////////////////
    chk_slot_answer: assert property (slot_stb |=> bit_stb)
        else $error("slot not answered");
    chk_bit_cause: assert property (bit_stb |-> $past(slot_stb))
        else $error("bit without slot");
    chk_line_idle: assert property (!bit_stb |-> bit_val)
        else $error("line low outside slot");
    chk_pullup_quiet: assert property (strong_pullup |-> !(byte_stb || slot_stb || init_pulse))
        else $error("traffic under pullup");
    chk_pullup_cause: assert property ($rose(strong_pullup) |->
        $past(byte_stb) && ($past(byte_val) inside {8'h44, 8'h48}))
        else $error("pullup without job byte");
    chk_pullup_length: assert property ($fell(strong_pullup) |->
        (pull_cnt_q == MEASURE_CYC || pull_cnt_q == COMMIT_CYC))
        else $error("pullup length wrong");
    chk_byte_alone: assert property (byte_stb |-> !slot_stb && !init_pulse)
        else $error("byte overlaps other strobe");
    chk_init_single: assert property (init_pulse |=> !init_pulse)
        else $error("init longer than one cycle");
    cov_pullup: cover property ($rose(strong_pullup));
    cov_low_bit: cover property (bit_stb && !bit_val);
    cov_readout: cover property (byte_stb && byte_val == 8'hbe);
endmodule

// [tb/thermo_scratchpad_alarm_bench.sv]
// Bench: both link ends driven through controller registers
`timescale 1ns/10ps
module thermo_scratchpad_alarm_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic parasite_pin = 1'b0;
    logic [15:0] sense_temp = 16'h0000;
    logic [15:0] temp_result;
    logic alarm_flag;
    logic job_busy;
    logic [7:0] sp [0:8];
    logic [7:0] v;
    logic b;
    int err_count = 0;
    int checked = 0;
    // Short job counts keep the run small; checker defaults equal these
    localparam int MEAS_CYC = 64;
    localparam int WRITE_CYC = 16;
    localparam int LOAD_CYC = 4;
    tsa_link_if link ();
    always #25 sys_clk = ~sys_clk;
    tsa_master_end #(.MEASURE_CYC(MEAS_CYC), .COMMIT_CYC(WRITE_CYC)) i_tsa_master_end (
        .sys_clk(sys_clk),
        .rst_n(rst_n), .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    tsa_sensor_end #(.MEASURE_CYC(MEAS_CYC), .COMMIT_CYC(WRITE_CYC), .RELOAD_CYC(LOAD_CYC))
        i_tsa_sensor_end (
        .sys_clk(sys_clk), .rst_n(rst_n), .link(link), .parasite_pin(parasite_pin),
        .sense_temp(sense_temp), .temp_result(temp_result), .alarm_flag(alarm_flag),
        .job_busy(job_busy));
    tsa_link_sva i_tsa_link_sva (.sys_clk(sys_clk),
        .rst_n(rst_n), .init_pulse(link.init_pulse), .byte_stb(link.byte_stb),
        .byte_val(link.byte_val), .slot_stb(link.slot_stb),
        .strong_pullup(link.strong_pullup), .bit_stb(link.bit_stb), .bit_val(link.bit_val));
    ////////////////////////////////////////
    task give_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
    // Bounded poll; a stuck busy counts as a mismatch
    task idle();
        logic [7:0] s;
        for (int n = 0; n < 300; n++) begin
            rd(4'h2, s);
            if (!s[0]) return;
        end
        chk(s, 8'h00);
    endtask
    task op(input logic [1:0] o);
        wr(4'h0, {6'h00, o});
        idle();
    endtask
    task sb(input logic [7:0] d);
        wr(4'h1, d);
        op(2'h2);
    endtask
    task slot(output logic q);
        logic [7:0] s;
        op(2'h3);
        rd(4'h2, s);
        q = s[1];
    endtask
    task rbyte(output logic [7:0] d);
        repeat (8) op(2'h3);
        rd(4'h3, d);
    endtask
    task cmd(input logic [7:0] c);
        op(2'h1);
        sb(8'hcc);
        sb(c);
    endtask
    task settle();
        repeat (300) begin
            @(negedge sys_clk);
            if (!job_busy) return;
        end
        chk(job_busy, 1'h0);
    endtask
    function automatic logic [7:0] crc();
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 64; i++)
            c = (c >> 1) ^ ((c[0] ^ sp[i / 8][i % 8]) ? 8'h8c : 8'h00);
        return c;
    endfunction
    task readout();
        cmd(8'hbe);
        sp[8] = crc();
        for (int i = 0; i < 9; i++) begin
            rbyte(v);
            chk(v, sp[i]);
        end
    endtask
    task load(input logic [7:0] c);
        cmd(8'h4e);
        sb(8'h19);
        sb(8'hf5);
        sb(c);
    endtask
    // Short conversions can end before the first slot lands
    task measure(input logic [15:0] t, input logic early);
        @(posedge sys_clk);
        sense_temp <= t;
        cmd(8'h44);
        slot(b);
        if (early) chk(b, 1'h0);
        if (early) chk(job_busy, 1'h1);
        settle();
        slot(b);
        chk(b, 1'h1);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(4'hf, v);
        chk(v, 8'h00);
        sp = '{8'h50, 8'h05, 8'h4b, 8'h46, 8'h7f, 8'hff, 8'h0c, 8'h10, 8'h00};
        readout();
        $display("test power-up image done");
        load(8'hff);
        measure(16'h0191, 1'h1);
        chk(alarm_flag, 1'h1);
        sp = '{8'h91, 8'h01, 8'h19, 8'hf5, 8'h7f, 8'hff, 8'h0c, 8'h10, 8'h00};
        readout();
        load(8'h1f);
        rd(4'h2, v);
        chk(v[4], 1'h1);
        measure(16'hff5f, 1'h0);
        chk(temp_result, 16'hff58);
        chk(alarm_flag, 1'h1);
        measure(16'h00a2, 1'h0);
        chk(temp_result, 16'h00a0);
        chk(alarm_flag, 1'h0);
        op(2'h1);
        sb(8'hec);
        rbyte(v);
        chk(v, 8'hff);
        measure(16'h0191, 1'h0);
        op(2'h1);
        sb(8'hec);
        rbyte(v);
        chk(v, 8'h5a);
        rbyte(v);
        chk(v, 8'hab);
        $display("test alarm done");
        cmd(8'h48);
        settle();
        cmd(8'h4e);
        sb(8'h20);
        sb(8'h10);
        sb(8'h5f);
        sb(8'h00);
        cmd(8'hb8);
        settle();
        slot(b);
        chk(b, 1'h1);
        sp = '{8'h90, 8'h01, 8'h19, 8'hf5, 8'h1f, 8'hff, 8'h0c, 8'h10, 8'h00};
        readout();
        $display("test commit reload done");
        @(posedge sys_clk);
        parasite_pin <= 1'b1;
        cmd(8'hb4);
        slot(b);
        chk(b, 1'h0);
        wr(4'h4, 8'h01);
        op(2'h1);
        sb(8'hcc);
        wr(4'h1, 8'h44);
        wr(4'h0, 8'h02);
        rd(4'h2, v);
        chk(v[2], 1'h1);
        chk(v[3], 1'h1);
        chk(v[4], 1'h0);
        idle();
        @(posedge sys_clk);
        parasite_pin <= 1'b0;
        cmd(8'hb4);
        slot(b);
        chk(b, 1'h1);
        $display("test supply done");
        give_verdict();
    end
endmodule
